/* src/serial_port_pkg.sv */
// Constants and types for the serial port block.
// Assumes a 50 MHz core clock and an APB master with 32-bit data.
package serial_port_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [9:0] IDX_POWER = 10'h087;
    localparam logic [9:0] IDX_CTL   = 10'h098;
    localparam logic [9:0] IDX_BUF   = 10'h099;
    localparam logic [9:0] IDX_FRAC  = 10'h09d;
    localparam logic [9:0] IDX_PRESC = 10'h09e;
    localparam logic [9:0] IDX_CFG   = 10'h0af;
    localparam logic [9:0] IDX_T2    = 10'h0c8;
    // Field positions.
    localparam int POS_DOUBLE  = 7;
    localparam int POS_BAUD_EN = 7;
    localparam int POS_EXTENDED_FEATURE_ENABLE   = 0;
    localparam int POS_TIMER2_TRANSMIT_CLOCK_SELECT    = 4;
    localparam int POS_RCLK    = 5;
    // Reset values.
    localparam logic [5:0] RST_FRAC  = 6'h00;
    localparam logic [7:0] RST_CTL   = 8'h00;
    localparam logic [2:0] RST_INT   = 3'h0;
    localparam logic [1:0] RST_EXT   = 2'h0;
    // Timing counts in core clock cycles.
    localparam logic [3:0]  M0_LAST   = 4'hb;  // Shift mode bit: 12 cycles.
    localparam logic [3:0]  M0_HALF   = 4'h6;
    localparam logic [1:0]  M2_SLOW   = 2'h3;  // 64/16 cycles per tick.
    localparam logic [1:0]  M2_FAST   = 2'h1;  // 32/16 cycles per tick.
    localparam logic [3:0]  OVS_LAST  = 4'hf;  // 16 ticks per bit.
    localparam logic [3:0]  OVS_MID   = 4'h7;
    localparam logic [17:0] FRAC_BASE = 18'h00040;
    localparam logic [3:0]  LAST_BIT8 = 4'h9;
    localparam logic [3:0]  LAST_BIT9 = 4'ha;
    localparam logic [3:0]  RX_FINAL  = 4'h8;

    typedef struct packed {
        logic modeSelectHigh;
        logic modeSelectLow;
        logic frameOrAddressCheck;
        logic receiveEnable;
        logic transmitNinthBit;
        logic receivedNinthBit;
        logic transmitFlag;
        logic receiveFlag;
    } serial_ctl_t;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_WAIT  = 2'b01,
        TX_SHIFT = 2'b10
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10
    } rx_state_t;
endpackage

/* src/serial_port.sv */
// Serial port with shift, 8-bit and 9-bit asynchronous modes.
// Assumes APB access, timer overflow pulses and synchronous pin inputs.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
// What this block does
// - Baud timer enable selects dedicated rate source
// - Enable clear selects legacy rate sources
// - Divider bit 6 ignores writes
// - Low six bits hold fraction, reset zero
// - Mode 0 shifts eight bits, core/12
// - Buffer write starts LSB-first shift out
// - Mode 0 receive when enabled and flag clear
// - Mode 1 frames: start, eight bits, stop
// - Mode 1 rate from timer overflows
// - Stop bit loaded; flag at stop
// - Falling edge starts reception, start checked
// - Flag clear needed unless extended features
// - Mode 1 frame check needs stop one
// - Failed frame dropped, flag unchanged
// - Accepted byte, stop bit, flag latched
// - Mode 2 rate core/64, doubled core/32
// - Mode 2 frames carry ninth bit
// - Ninth bit loaded; flag at stop
// - Address check needs ninth bit one
// - Accepted byte, ninth bit, flag latched
// - Mode 3 is mode 2 with variable rate
// - Baud timer rate with fractional multiplier
// - Prescale exponents at bits 2:0, 4:3
module serial_port (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer1Overflow,
    input  wire logic        timer2Overflow,
    input  wire logic        rxdIn,
    output logic             rxdOut,
    output logic             rxdOeN,
    output logic             txd
);
    import serial_port_pkg::*;

    serial_ctl_t ctl_reg;
    tx_state_t   txState_reg;
    rx_state_t   rxState_reg;
    logic [7:0]  rxBuf_reg;
    logic        doubleRate_reg;
    logic        baudEn_reg;
    logic [5:0]  fracDiv_reg;
    logic [2:0]  intExp_reg;
    logic [1:0]  extExp_reg;
    logic        extended_feature_enable_reg;
    logic        timer2_transmit_clock_select_reg;
    logic        rclk_reg;
    logic [17:0] acc_reg;
    logic        t1Half_reg;
    logic [1:0]  m2Cnt_reg;
    logic [10:0] txShift_reg;
    logic [3:0]  txCnt_reg;
    logic [3:0]  txBit_reg;
    logic [3:0]  txLast_reg;
    logic        txLine_reg;
    logic [8:0]  rxShift_reg;
    logic [3:0]  rxCnt_reg;
    logic [3:0]  rxBit_reg;
    logic        rxPrev_reg;
    logic        m0Active_reg;
    logic        m0IsRx_reg;
    logic [7:0]  m0Shift_reg;
    logic [3:0]  m0Cnt_reg;
    logic [2:0]  m0Bit_reg;

    logic [9:0]  regIdx;
    logic        access;
    logic        wrEn;
    logic        ctlWrite;
    logic        bufWrite;
    logic        hit;
    logic [7:0]  readData;
    logic        modeZero;
    logic        modeOne;
    logic        modeTwo;
    logic [3:0]  expSum;
    logic [17:0] threshold;
    logic [17:0] accSum;
    logic        utTick;
    logic        t1Tick;
    logic        m2Tick;
    logic        txTick;
    logic        rxTick;
    logic        txStopOut;
    logic        rxFinal;
    logic        rxAccept;
    logic        m0Start;
    logic        m0RxStart;
    logic        m0End;

    assign regIdx   = paddr[11:2];
    assign access   = psel & penable & pready;
    assign wrEn     = access & pwrite;
    assign ctlWrite = wrEn & (regIdx == IDX_CTL);
    assign bufWrite = wrEn & (regIdx == IDX_BUF);
    assign modeZero = ~ctl_reg.modeSelectHigh & ~ctl_reg.modeSelectLow;
    assign modeOne  = ~ctl_reg.modeSelectHigh & ctl_reg.modeSelectLow;
    assign modeTwo  = ctl_reg.modeSelectHigh & ~ctl_reg.modeSelectLow;

    // Each access takes one wait state; pready is high in the second
    // access cycle only.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            if (psel & penable & ~pready & ~pwrite) begin
                prdata <= {24'h00_0000, readData};
            end
        end
    end

    always_comb begin
        readData = 8'h00;
        hit      = 1'b1;
        unique case (regIdx)
            IDX_POWER: readData[POS_DOUBLE] = doubleRate_reg;
            IDX_CTL:   readData = ctl_reg;
            IDX_BUF:   readData = rxBuf_reg;
            IDX_FRAC: begin
                readData[POS_BAUD_EN] = baudEn_reg;
                readData[5:0] = fracDiv_reg;
            end
            IDX_PRESC: readData[4:0] = {extExp_reg, intExp_reg};
            IDX_CFG:   readData[POS_EXTENDED_FEATURE_ENABLE] = extended_feature_enable_reg;
            IDX_T2: begin
                readData[POS_TIMER2_TRANSMIT_CLOCK_SELECT] = timer2_transmit_clock_select_reg;
                readData[POS_RCLK] = rclk_reg;
            end
            default:   hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            doubleRate_reg <= 1'b0;
            baudEn_reg     <= 1'b0;
            fracDiv_reg    <= RST_FRAC;
            intExp_reg     <= RST_INT;
            extExp_reg     <= RST_EXT;
            extended_feature_enable_reg      <= 1'b0;
            timer2_transmit_clock_select_reg       <= 1'b0;
            rclk_reg       <= 1'b0;
        end else if (wrEn) begin
            unique case (regIdx)
                IDX_POWER: doubleRate_reg <= pwdata[POS_DOUBLE];
                IDX_FRAC: begin
                    baudEn_reg  <= pwdata[POS_BAUD_EN];
                    fracDiv_reg <= pwdata[5:0];
                end
                IDX_PRESC: begin
                    intExp_reg <= pwdata[2:0];
                    extExp_reg <= pwdata[4:3];
                end
                IDX_CFG:   extended_feature_enable_reg <= pwdata[POS_EXTENDED_FEATURE_ENABLE];
                IDX_T2: begin
                    timer2_transmit_clock_select_reg <= pwdata[POS_TIMER2_TRANSMIT_CLOCK_SELECT];
                    rclk_reg <= pwdata[POS_RCLK];
                end
                default: ;
            endcase
        end
    end

    // Baud timer: 16x tick at core * (64 + fraction) / (64 << exponent).
    assign expSum    = {1'b0, intExp_reg} + {2'b00, extExp_reg};
    assign threshold = FRAC_BASE << expSum;
    assign accSum    = acc_reg + FRAC_BASE + {12'h000, fracDiv_reg};
    assign utTick    = accSum >= threshold;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acc_reg <= 18'h00000;
        end else if (!baudEn_reg) begin
            acc_reg <= 18'h00000;
        end else begin
            acc_reg <= utTick ? accSum - threshold : accSum;
        end
    end

    // Timer 1 ticks every second overflow unless the rate is doubled.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            t1Half_reg <= 1'b0;
        end else if (timer1Overflow) begin
            t1Half_reg <= ~t1Half_reg;
        end
    end
    assign t1Tick = timer1Overflow & (doubleRate_reg | t1Half_reg);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            m2Cnt_reg <= 2'h0;
        end else begin
            m2Cnt_reg <= m2Tick ? 2'h0 : m2Cnt_reg + 2'h1;
        end
    end
    assign m2Tick = m2Cnt_reg == (doubleRate_reg ? M2_FAST : M2_SLOW);

    always_comb begin
        if (modeTwo) begin
            txTick = m2Tick;
            rxTick = m2Tick;
        end else if (baudEn_reg) begin
            txTick = utTick;
            rxTick = utTick;
        end else begin
            txTick = timer2_transmit_clock_select_reg ? timer2Overflow : t1Tick;
            rxTick = rclk_reg ? timer2Overflow : t1Tick;
        end
    end

    // Asynchronous transmitter.
    assign txStopOut = (txState_reg == TX_SHIFT) & txTick
                     & (txCnt_reg == OVS_LAST)
                     & (txBit_reg + 4'h1 == txLast_reg);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            txState_reg <= TX_IDLE;
            txShift_reg <= 11'h7ff;
            txCnt_reg   <= 4'h0;
            txBit_reg   <= 4'h0;
            txLast_reg  <= LAST_BIT8;
            txLine_reg  <= 1'b1;
        end else if (bufWrite && !modeZero) begin
            // Stop or programmed ninth bit sits in the ninth position.
            txShift_reg <= {1'b1, modeOne | ctl_reg.transmitNinthBit,
                            pwdata[7:0], 1'b0};
            txLast_reg  <= modeOne ? LAST_BIT8 : LAST_BIT9;
            txState_reg <= TX_WAIT;
        end else if (txTick) begin
            unique case (txState_reg)
                TX_IDLE: txLine_reg <= 1'b1;
                TX_WAIT: begin
                    txState_reg <= TX_SHIFT;
                    txLine_reg  <= txShift_reg[0];
                    txCnt_reg   <= 4'h0;
                    txBit_reg   <= 4'h0;
                end
                TX_SHIFT: begin
                    txCnt_reg <= txCnt_reg + 4'h1;
                    if (txCnt_reg == OVS_LAST) begin
                        txShift_reg <= {1'b1, txShift_reg[10:1]};
                        txLine_reg  <= txShift_reg[1];
                        txBit_reg   <= txBit_reg + 4'h1;
                        if (txBit_reg == txLast_reg) begin
                            txState_reg <= TX_IDLE;
                            txLine_reg  <= 1'b1;
                        end
                    end
                end
                default: txState_reg <= TX_IDLE;
            endcase
        end
    end

    // Asynchronous receiver.
    assign rxFinal  = (rxState_reg == RX_DATA) & rxTick
                    & (rxCnt_reg == OVS_LAST) & (rxBit_reg == RX_FINAL);
    assign rxAccept = rxFinal & (extended_feature_enable_reg | ~ctl_reg.receiveFlag)
                    & (~ctl_reg.frameOrAddressCheck | rxdIn);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rxPrev_reg <= 1'b1;
        end else begin
            rxPrev_reg <= rxdIn;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rxState_reg <= RX_IDLE;
            rxShift_reg <= 9'h000;
            rxCnt_reg   <= 4'h0;
            rxBit_reg   <= 4'h0;
        end else begin
            unique case (rxState_reg)
                RX_IDLE: begin
                    if (!modeZero && ctl_reg.receiveEnable
                        && rxPrev_reg && !rxdIn) begin
                        rxState_reg <= RX_START;
                        rxCnt_reg   <= 4'h0;
                    end
                end
                RX_START: begin
                    if (rxTick) begin
                        rxCnt_reg <= rxCnt_reg + 4'h1;
                        if (rxCnt_reg == OVS_MID) begin
                            // A start bit that is high again is noise.
                            rxState_reg <= rxdIn ? RX_IDLE : RX_DATA;
                            rxCnt_reg   <= 4'h0;
                            rxBit_reg   <= 4'h0;
                        end
                    end
                end
                RX_DATA: begin
                    if (rxTick) begin
                        rxCnt_reg <= rxCnt_reg + 4'h1;
                        if (rxCnt_reg == OVS_LAST) begin
                            rxShift_reg <= {rxdIn, rxShift_reg[8:1]};
                            rxBit_reg   <= rxBit_reg + 4'h1;
                            if (rxBit_reg == RX_FINAL) begin
                                rxState_reg <= RX_IDLE;
                            end
                        end
                    end
                end
                default: rxState_reg <= RX_IDLE;
            endcase
        end
    end

    // Shift register mode: data on the receive pin, clock on transmit.
    assign m0Start   = bufWrite & modeZero & ~m0Active_reg;
    assign m0RxStart = modeZero & ctl_reg.receiveEnable
                     & ~ctl_reg.receiveFlag & ~m0Active_reg
                     & ~bufWrite;
    assign m0End     = m0Active_reg & (m0Cnt_reg == M0_LAST)
                     & (m0Bit_reg == 3'h7);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            m0Active_reg <= 1'b0;
            m0IsRx_reg   <= 1'b0;
            m0Shift_reg  <= 8'h00;
            m0Cnt_reg    <= 4'h0;
            m0Bit_reg    <= 3'h0;
            rxdOut       <= 1'b1;
            rxdOeN       <= 1'b1;
        end else if (m0Start) begin
            m0Active_reg <= 1'b1;
            m0IsRx_reg   <= 1'b0;
            m0Shift_reg  <= pwdata[7:0];
            m0Cnt_reg    <= 4'h0;
            m0Bit_reg    <= 3'h0;
            rxdOut       <= pwdata[0];
            rxdOeN       <= 1'b0;
        end else if (m0RxStart) begin
            m0Active_reg <= 1'b1;
            m0IsRx_reg   <= 1'b1;
            m0Cnt_reg    <= 4'h0;
            m0Bit_reg    <= 3'h0;
            rxdOeN       <= 1'b1;
        end else if (m0Active_reg) begin
            m0Cnt_reg <= (m0Cnt_reg == M0_LAST) ? 4'h0 : m0Cnt_reg + 4'h1;
            if (m0Cnt_reg == M0_LAST) begin
                m0Bit_reg <= m0Bit_reg + 3'h1;
                if (m0IsRx_reg) begin
                    m0Shift_reg <= {rxdIn, m0Shift_reg[7:1]};
                end else begin
                    m0Shift_reg <= {1'b0, m0Shift_reg[7:1]};
                    rxdOut      <= m0Shift_reg[1];
                end
                if (m0End) begin
                    m0Active_reg <= 1'b0;
                    rxdOeN       <= 1'b1;
                    rxdOut       <= 1'b1;
                end
            end
        end
    end

    // The shift clock is low for the first half of each 12-cycle bit.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            txd <= 1'b1;
        end else if (modeZero) begin
            txd <= ~(m0Active_reg & (m0Cnt_reg < M0_HALF));
        end else begin
            txd <= txLine_reg;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rxBuf_reg <= 8'h00;
        end else if (rxAccept) begin
            rxBuf_reg <= rxShift_reg[8:1];
        end else if (m0End && m0IsRx_reg) begin
            rxBuf_reg <= {rxdIn, m0Shift_reg[7:1]};
        end
    end

    // Hardware sets win over a software write in the same cycle.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctl_reg <= RST_CTL;
        end else begin
            if (ctlWrite) begin
                ctl_reg <= pwdata[7:0];
            end
            if (txStopOut || (m0End && !m0IsRx_reg)) begin
                ctl_reg.transmitFlag <= 1'b1;
            end
            if (rxAccept) begin
                ctl_reg.receivedNinthBit <= rxdIn;
                ctl_reg.receiveFlag      <= 1'b1;
            end
            if (m0End && m0IsRx_reg) begin
                ctl_reg.receiveFlag <= 1'b1;
            end
        end
    end

    fracWrite_a: assert property (@(posedge core_clk) disable iff (rst)
        wrEn && regIdx == IDX_FRAC |=> fracDiv_reg == $past(pwdata[5:0])
        && baudEn_reg == $past(pwdata[7]))
        else $error("fraction register write not stored");
    dedSource_a: assert property (@(posedge core_clk) disable iff (rst)
        baudEn_reg && !modeTwo |-> txTick == utTick && rxTick == utTick)
        else $error("baud timer not used as rate source");
    legacySource_a: assert property (@(posedge core_clk) disable iff (rst)
        !baudEn_reg && !modeTwo && !timer2_transmit_clock_select_reg |-> txTick == t1Tick)
        else $error("legacy rate source not used");
    shiftClock_a: assert property (@(posedge core_clk) disable iff (rst)
        modeZero && m0Active_reg && m0Cnt_reg == 4'h0 && !ctlWrite
        |=> !txd [*6] ##1 txd)
        else $error("shift clock low phase wrong");
    shiftTxStart_a: assert property (@(posedge core_clk) disable iff (rst)
        m0Start |=> m0Active_reg && !rxdOeN && rxdOut == $past(pwdata[0]))
        else $error("shift transmit did not start");
    shiftRxStart_a: assert property (@(posedge core_clk) disable iff (rst)
        m0RxStart |=> m0Active_reg && m0IsRx_reg && rxdOeN)
        else $error("shift receive did not start");
    stopFlag_a: assert property (@(posedge core_clk) disable iff (rst)
        txStopOut |=> ctl_reg.transmitFlag && txLine_reg ##1 txd)
        else $error("transmit flag not set at stop bit");
    keepUnread_a: assert property (@(posedge core_clk) disable iff (rst)
        rxFinal && !extended_feature_enable_reg && ctl_reg.receiveFlag && !ctlWrite
        |=> rxBuf_reg == $past(rxBuf_reg) && ctl_reg.receiveFlag)
        else $error("unread byte overwritten");
    acceptLatch_a: assert property (@(posedge core_clk) disable iff (rst)
        rxAccept |=> ctl_reg.receiveFlag && rxBuf_reg == $past(rxShift_reg[8:1])
        && ctl_reg.receivedNinthBit == $past(rxdIn))
        else $error("accepted frame not latched");
    // No transfer under way at the tick, so doubling can change only at
    // the fourth edge, where the faster rate then takes over.
    slowRate_a: assert property (@(posedge core_clk) disable iff (rst)
        m2Tick && !doubleRate_reg && !psel
        |=> !m2Tick [*3] ##1 (m2Tick || doubleRate_reg))
        else $error("fixed rate tick spacing wrong");

    txDone_c: cover property (@(posedge core_clk) disable iff (rst)
        txStopOut);
    rxOk_c: cover property (@(posedge core_clk) disable iff (rst)
        rxAccept);
    rxDrop_c: cover property (@(posedge core_clk) disable iff (rst)
        rxFinal && !rxAccept);
    shiftDone_c: cover property (@(posedge core_clk) disable iff (rst)
        m0End);
endmodule // serial_port

/* test/remote_node.sv */
// Remote serial node: drives frames on the receive pin, captures txd.
// Assumes the bench feeds rxdIn from this model and calls its tasks.
`timescale 1ns/1ps
module remote_node (
    input  wire logic core_clk,
    input  wire logic txd,
    input  wire logic rxdOut,
    input  wire logic rxdOeN,
    output logic      rxdIn
);
    logic lineDrive = 1'b1;
    // The pin has a pull-up; the device's drive wins while enabled.
    assign rxdIn = rxdOeN ? lineDrive : rxdOut;

    // Sends a start bit, nBits bits LSB first, then a stop bit.
    task automatic sendFrame(input logic [8:0] bits, input int nBits,
                             input int period);
        lineDrive <= 1'b0;
        repeat (period) @(posedge core_clk);
        for (int i = 0; i < nBits; i++) begin
            lineDrive <= bits[i];
            repeat (period) @(posedge core_clk);
        end
        lineDrive <= 1'b1;
        repeat (period) @(posedge core_clk);
    endtask

    // Feeds a shift mode receive: each bit is changed while the shift
    // clock is low, then held until the device has taken the last one.
    task automatic feedShift(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            while (txd !== 1'b0) @(posedge core_clk);
            lineDrive <= d[i];
            while (txd !== 1'b1) @(posedge core_clk);
        end
        repeat (6) @(posedge core_clk);
        lineDrive <= 1'b1;
    endtask

    // Samples a frame at mid-bit, start bit in got[0].
    task automatic getFrame(input int total, input int period,
                            output logic [31:0] got);
        int n;
        got = '0;
        n = 0;
        while (txd !== 1'b0 && n < 5000) begin
            @(posedge core_clk);
            n++;
        end
        repeat (period / 2) @(posedge core_clk);
        for (int i = 0; i < total; i++) begin
            got[i] = txd;
            if (i < total - 1) repeat (period) @(posedge core_clk);
        end
    endtask
endmodule // remote_node

/* test/serial_port_tb.sv */
// Bench for the serial port: registers over APB, frames in modes 0, 1 and 2.
// Assumes remote_node as the far side of the serial pins.
`timescale 1ns/1ps
module serial_port_tb;
    import serial_port_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, rxdIn, rxdOut, rxdOeN, txd;
    logic [31:0] got, rd;
    logic        er;
    logic        ovf      = 1'b0;
    int          err_total = 0, n_compared = 0, cycles = 0, k;

    serial_port DUT (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer1Overflow(ovf),
        .timer2Overflow(~ovf), .rxdIn(rxdIn), .rxdOut(rxdOut),
        .rxdOeN(rxdOeN), .txd(txd));
    remote_node node (.core_clk(core_clk), .txd(txd), .rxdOut(rxdOut),
        .rxdOeN(rxdOeN), .rxdIn(rxdIn));

    always #10 core_clk = ~core_clk;

    // Timer overflow pulses on every other cycle.
    always @(posedge core_clk) ovf <= ~ovf;

    task automatic conclude;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [9:0] idx,
                       input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rdchk(input logic [9:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        check(rd, {24'h0, e});
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rdchk(IDX_FRAC, 8'h00);
        apb(1'b1, IDX_FRAC, 8'hff);
        rdchk(IDX_FRAC, 8'hbf);
        apb(1'b1, IDX_PRESC, 8'h1f);
        rdchk(IDX_PRESC, 8'h1f);
        apb(1'b0, 10'h000, 8'h00);
        check({31'h0, er}, 32'h1);
        apb(1'b1, IDX_FRAC, 8'h00);
        apb(1'b1, IDX_PRESC, 8'h00);
        // Shift mode: data on the receive pin at each shift clock rise.
        apb(1'b1, IDX_BUF, 8'h96);
        got = '0;
        for (int i = 0; i < 8; i++) begin
            k = 0;
            while (txd !== 1'b0 && k < 40) begin
                @(posedge core_clk);
                k++;
            end
            while (txd !== 1'b1 && k < 40) begin
                @(posedge core_clk);
                k++;
            end
            got[i] = rxdOut;
            check({31'h0, rxdOeN}, 32'h0);
            if (i > 0) check(32'(k), 32'd12);
        end
        check(got, 32'h96);
        // Shift mode receive once the transmission has ended.
        repeat (6) @(posedge core_clk);
        apb(1'b1, IDX_CTL, 8'h10);
        node.feedShift(8'h69);
        rdchk(IDX_CTL, 8'h11);
        rdchk(IDX_BUF, 8'h69);
        // Nine-bit fixed rate, plain then doubled.
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, IDX_POWER, s ? 8'h80 : 8'h00);
            apb(1'b1, IDX_CTL, 8'h88);
            apb(1'b1, IDX_BUF, 8'ha5);
            node.getFrame(11, s ? 32 : 64, got);
            check(got, 32'h74a);
            rdchk(IDX_CTL, 8'h8a);
        end
        apb(1'b1, IDX_CTL, 8'hb0);
        node.sendFrame(9'h0a5, 9, 32);
        rdchk(IDX_CTL, 8'hb0);
        node.sendFrame(9'h1c3, 9, 32);
        rdchk(IDX_CTL, 8'hb5);
        rdchk(IDX_BUF, 8'hc3);
        // Eight-bit mode on the baud timer; doubling stays set.
        apb(1'b1, IDX_FRAC, 8'h80);
        apb(1'b1, IDX_CTL, 8'h50);
        apb(1'b1, IDX_BUF, 8'h5a);
        node.getFrame(10, 16, got);
        check(got, 32'h2b4);
        rdchk(IDX_CTL, 8'h52);
        apb(1'b1, IDX_CTL, 8'h50);
        node.sendFrame(9'h03c, 8, 16);
        rdchk(IDX_CTL, 8'h55);
        rdchk(IDX_BUF, 8'h3c);
        node.sendFrame(9'h0c3, 8, 16);
        rdchk(IDX_BUF, 8'h3c);
        apb(1'b1, IDX_CFG, 8'h01);
        node.sendFrame(9'h0c3, 8, 16);
        rdchk(IDX_BUF, 8'hc3);
        // Eight-bit mode on Timer 1, then transmit on Timer 2.
        apb(1'b1, IDX_FRAC, 8'h00);
        apb(1'b1, IDX_POWER, 8'h00);
        apb(1'b1, IDX_CTL, 8'h40);
        apb(1'b1, IDX_BUF, 8'h3c);
        node.getFrame(10, 64, got);
        check(got, 32'h278);
        apb(1'b1, IDX_T2, 8'h10);
        apb(1'b1, IDX_BUF, 8'h96);
        node.getFrame(10, 32, got);
        check(got, 32'h32c);
        conclude();
    end
endmodule // serial_port_tb
